/* File: core/cpu_ident_unit.sv */
// Identification logic: identity instruction, identification and control registers
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"

module cpu_ident_unit #(
    parameter logic [3:0] RATIO_CODE = `RATIO_DEFAULT
) (
    input wire logic CLK,
    input wire logic RST,
    input wire ident_pkg::io_req_t IO_REQ,
    output logic [7:0] IO_RDATA,
    output logic IO_CLAIMED,
    input wire ident_pkg::exec_req_t EXEC_REQ,
    output ident_pkg::gpr_set_t RESULT,
    output logic [31:0] FLAGS_OUT,
    output logic RESULT_VALID,
    output logic IDENT_FAULT,
    output logic IDENT_ENABLED
);
    import ident_pkg::*;

    ident_state_t s_reg;
    ident_state_t s_next;
    logic [7:0] ident_0;
    logic map_open;
    logic reachable;

    // ****************************************
    // Hardwired identification value and index reachability
    // ****************************************
    assign ident_0 = {`FAMILY_CODE, RATIO_CODE};
    assign map_open = (s_reg.ctrl_three[`CFG_MAP_LSB +: 4] == `CFG_MAP_OPEN);

    always_comb begin
        reachable = map_open;
        if (s_reg.index >= `IDX_ALWAYS_LO && s_reg.index <= `IDX_ALWAYS_HI) begin
            reachable = 1'b1;
        end
        if (s_reg.index >= `IDX_TOP_LO) begin
            reachable = 1'b1;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.claimed = 1'b0;
        s_next.res_valid = 1'b0;
        s_next.ident_fault = 1'b0;
        // Index then data through the two ports
        if (IO_REQ.valid) begin
            if (IO_REQ.port == `PORT_INDEX && IO_REQ.write) begin
                s_next.index = IO_REQ.wdata;
                s_next.state = ST_INDEXED;
            end else if (IO_REQ.port == `PORT_DATA) begin
                case (s_reg.state)
                    ST_INDEXED: begin
                        s_next.state = ST_DONE;  // fresh index needed
                        if (reachable) begin
                            s_next.claimed = 1'b1;
                            if (IO_REQ.write) begin
                                case (s_reg.index)
                                    `IDX_CTRL_FOUR: s_next.ctrl_four = IO_REQ.wdata;
                                    `IDX_CTRL_THREE: s_next.ctrl_three = IO_REQ.wdata;
                                    default: ;  // Identification writes dropped
                                endcase
                            end else begin
                                case (s_reg.index)
                                    `IDX_IDENT_0: s_next.rdata = ident_0;
                                    `IDX_IDENT_1: s_next.rdata = `STEPPING_CODE;
                                    `IDX_CTRL_FOUR: s_next.rdata = s_reg.ctrl_four;
                                    `IDX_CTRL_THREE: s_next.rdata = s_reg.ctrl_three;
                                    default: s_next.rdata = 8'h00;
                                endcase
                            end
                        end
                    end
                    ST_IDLE, ST_DONE: ;
                    default: s_next.state = ST_IDLE;
                endcase
            end
        end
        s_next.ident_enable = s_next.ctrl_four[`CTRL_FOUR_ID_BIT];

        // Instruction execution
        if (EXEC_REQ.valid) begin
            s_next.flags = EXEC_REQ.flags_in;
            if (EXEC_REQ.opcode == `OPCODE_IDENT) begin
                if (!s_reg.ident_enable) begin
                    s_next.ident_fault = 1'b1;
                end else begin
                    s_next.res_valid = 1'b1;
                    if (EXEC_REQ.eax_in == `LEAF_VENDOR) begin
                        s_next.gpr.eax = `LEAF_MAX;
                        s_next.gpr.ebx = `VENDOR_B;
                        s_next.gpr.edx = `VENDOR_D;
                        s_next.gpr.ecx = `VENDOR_C;
                    end else if (EXEC_REQ.eax_in == `LEAF_FEATURE) begin
                        s_next.gpr.eax = {16'h0000, `FAMILY_WORD, `MODEL_BYTE};
                        s_next.gpr.edx = `FEATURE_WORD;
                    end
                    // Other leaves keep prior contents
                end
            end else if (EXEC_REQ.opcode == `OPCODE_DIV) begin
                s_next.res_valid = 1'b1;
                s_next.flags = EXEC_REQ.flags_in;  // Undefined flags unchanged
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.ctrl_four <= `CTRL_FOUR_RESET;
            s_reg.ident_enable <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign IO_RDATA = s_reg.rdata;
    assign IO_CLAIMED = s_reg.claimed;
    assign RESULT = s_reg.gpr;
    assign FLAGS_OUT = s_reg.flags;
    assign RESULT_VALID = s_reg.res_valid;
    assign IDENT_FAULT = s_reg.ident_fault;
    assign IDENT_ENABLED = s_reg.ident_enable;
endmodule : cpu_ident_unit
`default_nettype wire

/* File: core/ident_map.svh */
// Register map, field positions, reset values and codes of the identification unit
//
// Operation
// - Divide of five by two leaves every undefined arithmetic flag at its prior value.
// - Two 8-bit identification registers sit at configuration indexes FEh and FFh.
// - First identification register bits 7:4 return a fixed hardwired family code.
// - First identification register bits 3:0 encode the core-to-bus clock ratio.
// - Second identification register returns a hardwired stepping code.
// - Identity instruction enable is bit 7 of control register four, reset one.
// - Opcode 0FA2h is the identity instruction; EAX selects the leaf.
// - Leaf 0 writes 1 into EAX as the highest supported leaf.
// - Leaf 0 returns twelve vendor characters in EBX, EDX, ECX, low byte first.
// - Leaf 1 loads EAX 7:0 with 00h and EAX 15:8 with the family.
// - Leaf 1 loads EDX with the feature word 0080A135h.
// - Other leaves leave EAX, EBX, ECX and EDX undefined.
// - Indexes FC to FFh are reachable whatever the map-enable field holds.
`ifndef IDENT_MAP_SVH
`define IDENT_MAP_SVH

`define PORT_INDEX 8'h22
`define PORT_DATA 8'h23
`define IDX_CTRL_FOUR 8'hE8
`define IDX_CTRL_THREE 8'hC3
`define IDX_IDENT_0 8'hFE
`define IDX_IDENT_1 8'hFF
`define IDX_ALWAYS_LO 8'hC0
`define IDX_ALWAYS_HI 8'hCF
`define IDX_TOP_LO 8'hFC
`define CFG_MAP_LSB 0
`define CFG_MAP_OPEN 4'h1
`define CTRL_FOUR_RESET 8'h80
`define CTRL_FOUR_ID_BIT 7
`define OPCODE_IDENT 16'h0FA2
`define OPCODE_DIV 16'h00F7
`define LEAF_VENDOR 32'h0000_0000
`define LEAF_FEATURE 32'h0000_0001
`define LEAF_MAX 32'h0000_0001
`define FEATURE_WORD 32'h0080_A135
`define MODEL_BYTE 8'h00
`define RATIO_DEFAULT 4'h1
// Arbitrary neutral identity values
`define FAMILY_CODE 4'hA
`define FAMILY_WORD 8'h0A
`define STEPPING_CODE 8'h10
`define VENDOR_B 32'h6F4E_6547
`define VENDOR_D 32'h6369_7265
`define VENDOR_C 32'h5550_4320

`endif

/* File: core/ident_pkg.sv */
// Types shared by the identification unit
package ident_pkg;
    typedef struct packed {
        logic [31:0] eax;
        logic [31:0] ebx;
        logic [31:0] ecx;
        logic [31:0] edx;
    } gpr_set_t;

    typedef struct packed {
        logic valid;
        logic [15:0] opcode;
        logic [31:0] eax_in;
        logic [31:0] flags_in;
    } exec_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] port;
        logic [7:0] wdata;
    } io_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INDEXED = 3'b010,
        ST_DONE = 3'b100
    } cfg_state_t;

    typedef struct packed {
        cfg_state_t state;
        logic [7:0] index;
        logic [7:0] ctrl_four;
        logic [7:0] ctrl_three;
        logic [7:0] rdata;
        logic claimed;
        logic ident_enable;
        gpr_set_t gpr;
        logic [31:0] flags;
        logic res_valid;
        logic ident_fault;
    } ident_state_t;
endpackage : ident_pkg

/* File: tb/cpu_ident_unit_monitor.sv */
// Port checker of the identification unit
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"
module cpu_ident_unit_monitor #(
    parameter logic [3:0] RATIO_CODE = `RATIO_DEFAULT
) (
    input wire logic CLK,
    input wire logic RST,
    input wire ident_pkg::io_req_t IO_REQ,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_CLAIMED,
    input wire ident_pkg::exec_req_t EXEC_REQ,
    input wire ident_pkg::gpr_set_t RESULT,
    input wire logic [31:0] FLAGS_OUT,
    input wire logic RESULT_VALID,
    input wire logic IDENT_FAULT,
    input wire logic IDENT_ENABLED
);
    import ident_pkg::*;
    // ****
    // Properties
    // ****
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic id_op = EXEC_REQ.valid && EXEC_REQ.opcode == `OPCODE_IDENT;
    wire logic [31:0] leaf = EXEC_REQ.eax_in;
    sequence sel(x);
        IO_REQ.valid && IO_REQ.write && IO_REQ.port == `PORT_INDEX && IO_REQ.wdata == x;
    endsequence
    sequence rd;
        IO_REQ.valid && !IO_REQ.write && IO_REQ.port == `PORT_DATA;
    endsequence
    a_ident0_read: assert property (sel(`IDX_IDENT_0) ##2 rd |=>
        IO_CLAIMED && IO_RDATA == {`FAMILY_CODE, RATIO_CODE}) else $error("ident 0 bad");
    a_ident1_read: assert property (sel(`IDX_IDENT_1) ##2 rd |=>
        IO_CLAIMED && IO_RDATA == `STEPPING_CODE) else $error("ident 1 bad");
    a_stale_data: assert property (rd ##1 !(IO_REQ.valid && IO_REQ.port == `PORT_INDEX) ##1 rd |=>
        !IO_CLAIMED)
        else $error("stale access claimed");
    a_leaf_zero: assert property (id_op && IDENT_ENABLED && leaf == 0 |=>
        RESULT_VALID && RESULT == {`LEAF_MAX, `VENDOR_B, `VENDOR_C, `VENDOR_D})
        else $error("leaf 0 bad");
    a_leaf_one: assert property (id_op && IDENT_ENABLED && leaf == 1 |=>
        RESULT.eax[15:0] == {`FAMILY_WORD, `MODEL_BYTE} && RESULT.edx == `FEATURE_WORD)
        else $error("leaf 1 bad");
    a_div_flags: assert property (EXEC_REQ.valid && EXEC_REQ.opcode == `OPCODE_DIV |=>
        RESULT_VALID && FLAGS_OUT == $past(EXEC_REQ.flags_in)) else $error("flags moved");
    a_fault_off: assert property (id_op && !IDENT_ENABLED |=>
        IDENT_FAULT && !RESULT_VALID && $stable(RESULT)) else $error("no fault");
    a_enable_reset: assert property ($fell(RST) |-> IDENT_ENABLED)
        else $error("enable not set");
endmodule : cpu_ident_unit_monitor
bind cpu_ident_unit cpu_ident_unit_monitor #(.RATIO_CODE(RATIO_CODE)) mon (.CLK(CLK),
    .RST(RST), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_CLAIMED(IO_CLAIMED),
    .EXEC_REQ(EXEC_REQ), .RESULT(RESULT), .FLAGS_OUT(FLAGS_OUT), .RESULT_VALID(RESULT_VALID),
    .IDENT_FAULT(IDENT_FAULT), .IDENT_ENABLED(IDENT_ENABLED));
`default_nettype wire

/* File: tb/cpu_ident_unit_test.sv */
// Self-checking bench of the identification unit
`timescale 1ns/1ps
`default_nettype none
`include "ident_map.svh"
module cpu_ident_unit_test;
    import ident_pkg::*;
    logic CLK = 0;
    logic RST = 1;
    io_req_t io_req = '0;
    exec_req_t ex_req = '0;
    logic [7:0] rdata;
    logic claimed, valid, fault, enabled;
    gpr_set_t res;
    logic [31:0] flags;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] id0 = {`FAMILY_CODE, `RATIO_DEFAULT};
    cpu_ident_unit dut (.CLK(CLK), .RST(RST), .IO_REQ(io_req), .IO_RDATA(rdata),
        .IO_CLAIMED(claimed), .EXEC_REQ(ex_req), .RESULT(res), .FLAGS_OUT(flags),
        .RESULT_VALID(valid), .IDENT_FAULT(fault), .IDENT_ENABLED(enabled));
    // ****
    // Drivers and compare
    // ****
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic step();
        @(posedge CLK);
        #1;
    endtask : step
    task automatic io(input logic [7:0] p, input logic w, input logic [7:0] d);
        step();
        io_req = '{1'h1, w, p, d};
        step();
        io_req.valid = 1'h0;
    endtask : io
    task automatic cfg(input logic s, input logic [7:0] i, input logic w, input logic [7:0] d);
        if (s) io(`PORT_INDEX, 1'h1, i);
        io(`PORT_DATA, w, d);
    endtask : cfg
    task automatic ex(input logic [15:0] op, input logic [31:0] a, input logic [31:0] f);
        step();
        ex_req = '{1'h1, op, a, f};
        step();
        ex_req.valid = 1'h0;
    endtask : ex
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // ****
    // Tests
    // ****
    task automatic t_regs();
        cfg(1'h1, `IDX_IDENT_0, 1'h0, 8'h00);
        chk("ident0", id0, rdata);
        cfg(1'h1, `IDX_IDENT_0, 1'h1, 8'h00);
        cfg(1'h1, `IDX_IDENT_0, 1'h0, 8'h00);
        chk("ident0 kept", id0, rdata);
        cfg(1'h1, `IDX_IDENT_1, 1'h1, 8'hFF);
        cfg(1'h1, `IDX_IDENT_1, 1'h0, 8'h00);
        chk("ident1", `STEPPING_CODE, rdata);
        cfg(1'h0, 8'h00, 1'h0, 8'h00);
        chk("stale claim", 1'h0, claimed);
        cfg(1'h1, 8'hD0, 1'h0, 8'h00);
        chk("shut claim", 1'h0, claimed);
        cfg(1'h1, `IDX_CTRL_THREE, 1'h1, {4'h0, `CFG_MAP_OPEN});
        cfg(1'h1, 8'hD0, 1'h0, 8'h00);
        chk("open claim", 1'h1, claimed);
        cfg(1'h1, `IDX_IDENT_0, 1'h0, 8'h00);
        chk("ident0 open", id0, rdata);
        $display("regs test done");
    endtask : t_regs
    task automatic t_ident();
        ex(`OPCODE_IDENT, `LEAF_VENDOR, 32'h0);
        chk("leaf0 valid", 1'h1, valid);
        chk("leaf0 eax", `LEAF_MAX, res.eax);
        chk("ebx", `VENDOR_B, res.ebx);
        ex(`OPCODE_IDENT, `LEAF_FEATURE, 32'h0);
        chk("leaf1 eax", {16'h0000, `FAMILY_WORD, `MODEL_BYTE}, res.eax);
        chk("edx", `FEATURE_WORD, res.edx);
        cfg(1'h1, `IDX_CTRL_FOUR, 1'h1, 8'h00);
        ex(`OPCODE_IDENT, `LEAF_VENDOR, 32'h0);
        chk("enabled", 1'h0, enabled);
        chk("fault", 1'h1, fault);
        chk("edx kept", `FEATURE_WORD, res.edx);
        ex(`OPCODE_DIV, 32'h5, 32'h0000_08D5);
        chk("div flags", 32'h0000_08D5, flags);
        $display("ident test done");
    endtask : t_ident
    initial begin
        forever #25 CLK = ~CLK;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge CLK);
        #1;
        RST = 0;
        chk("reset enable", 1'h1, enabled);
        t_regs();
        t_ident();
        end_sim();
    end
endmodule : cpu_ident_unit_test
`default_nettype wire
